// ===== common/bus_resp_map.svh
// Code, port and field constants for the memory bus responder.
`ifndef BUS_RESP_MAP_SVH
`define BUS_RESP_MAP_SVH
`define CODE_FETCH 5'h00
`define CODE_BRANCH 5'h01
`define CODE_OPERAND_DC 5'h02
`define CODE_OPERAND_PC 5'h03
`define CODE_NO_TRANSFER 5'h04
`define CODE_VECTOR_LO 5'h0f
`define CODE_VECTOR_HI 5'h13
`define CODE_PC_HI_LOAD 5'h14
`define CODE_SPC_HI_LOAD 5'h15
`define CODE_DC_HI_LOAD 5'h16
`define CODE_PC_LO_LOAD 5'h17
`define CODE_SPC_LO_LOAD 5'h18
`define CODE_DC_LO_LOAD 5'h19
`define CODE_PORT_WRITE 5'h1a
`define CODE_PORT_READ 5'h1b
`define CODE_PORT_SELECT 5'h1c
`define CODE_PC_LO_OUT 5'h1e
`define CODE_PC_HI_OUT 5'h1f
`define PORT_DATA_A 2'h0
`define PORT_DATA_B 2'h1
`define PORT_INT_CTRL 2'h2
`define PORT_TIMER 2'h3
`define CTRL_EXT_ENABLE 0
`define CTRL_TIMER_ENABLE 1
`endif

// ===== common/bus_resp_pkg.sv
// Types shared by the memory bus responder.
package bus_resp_pkg;
  typedef struct packed {
    logic enable;
    logic [7:0] data;
  } drive_type;
  typedef enum logic [1:0] {
    SRC_NONE = 2'b00,
    SRC_EXT = 2'b01,
    SRC_TIMER = 2'b11
  } source_type;
endpackage

// ===== src/strobe_edge.sv
// One-cycle pulse on a chosen edge of a synchronous input.
`timescale 1ns/1ns
`default_nettype none
module strobe_edge #(
  parameter bit RISING = 1'b1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic level,
  output logic pulse
);
  logic prior;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prior <= RISING ? 1'b0 : 1'b1;
    end else begin
      prior <= level;
    end
  end
  assign pulse = RISING ? (level & ~prior) : (~level & prior);
endmodule // strobe_edge
`default_nettype wire

// ===== src/memory_bus_responder.sv
// Bus response, I/O ports and priority-chained interrupt of the storage companion.
`timescale 1ns/1ns
`default_nettype none
`include "bus_resp_map.svh"
// Summary of operation
// [R1] On code 0f, when this device owns the granted interrupt, the vector low byte goes on the bus.
// [R2] On code 13, when this device owns the granted interrupt, the vector high byte goes on the bus.
// [R3] On code 1b, when the selected port is one of ours, that port's byte goes on the bus.
// [R4] On code 1a the processor drives a byte, which we load into the selected port if it is ours.
// [R5] The interrupt request is asserted only while the active-low priority chain input is 0.
// [R6] An interrupt already pending asserts the request as soon as the chain input enables it.
// [R7] Memory-sourced codes drive the bus only for addresses inside our own segment.
// [R8] Address registers update on the write strobe; the timer is stepped by the phase clock.
// [R9] Codes where the processor sources data, or nothing moves, leave our drivers released.
module memory_bus_responder #(
  parameter logic [15:0] SEGMENT_BASE = 16'h0000,
  parameter int SEGMENT_SIZE = 1024,
  parameter logic [7:0] IO_BASE = 8'h04,
  parameter logic [15:0] EXT_VECTOR = 16'h0080,    // Arbitrary value.
  parameter logic [15:0] TIMER_VECTOR = 16'h0000,  // Arbitrary value.
  parameter logic [7:0] TIMER_PRESCALE = 8'h1f
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic PHI,
  input wire logic WRITE_STROBE,
  input wire logic [4:0] BUS_CONTROL_CODE,
  input wire logic [7:0] DB_IN,
  input wire logic PRIORITY_CHAIN_IN,
  input wire logic EXTERNAL_INTERRUPT_INPUT,
  output logic [7:0] DB_OUT,
  output logic DB_OE_B,
  output logic DATA_BUS_DRIVE_FLAG,
  output logic INT_REQ_B,
  output logic PRIORITY_CHAIN_OUT,
  output logic [7:0] PORT_A,
  output logic [7:0] PORT_B
);
  import bus_resp_pkg::*;

  localparam int SEG_BITS = $clog2(SEGMENT_SIZE);

  generate
    if (SEGMENT_SIZE < 2 || SEGMENT_SIZE > 32768 || (SEGMENT_SIZE & (SEGMENT_SIZE - 1)) != 0)
      $error("SEGMENT_SIZE must be a power of two from 2 to 32768");
    if (IO_BASE[1:0] != 2'h0)
      $error("IO_BASE must be a multiple of four");
    if (TIMER_PRESCALE == 8'h00)
      $error("TIMER_PRESCALE must not be zero");
  endgenerate

  // ==========================================================
  // Strobe edges
  logic write_rise, phi_rise, ext_fall;
  strobe_edge #(.RISING(1'b1)) u_write (.clk(CLK), .rst_b(RST_B), .level(WRITE_STROBE),
    .pulse(write_rise));
  strobe_edge #(.RISING(1'b1)) u_phi (.clk(CLK), .rst_b(RST_B), .level(PHI), .pulse(phi_rise));
  strobe_edge #(.RISING(1'b0)) u_ext (.clk(CLK), .rst_b(RST_B),
    .level(EXTERNAL_INTERRUPT_INPUT), .pulse(ext_fall));

  // ==========================================================
  // Mask storage
  // The contents stand in for the mask pattern until a real image is supplied.
  logic [7:0] rom [SEGMENT_SIZE];
  always_comb begin
    for (int i = 0; i < SEGMENT_SIZE; i++) begin
      rom[i] = 8'(i) ^ 8'(i >> 8);
    end
  end

  // ==========================================================
  // Cycle code, address registers and ports
  logic [4:0] code_now, next_code_now;
  logic [7:0] port_sel, next_port_sel;
  logic [15:0] program_counter, next_program_counter;
  logic [15:0] saved_program_counter, next_saved_program_counter;
  logic [15:0] data_counter, next_data_counter;
  logic [7:0] port_a, next_port_a, port_b, next_port_b;
  logic [7:0] int_ctrl, next_int_ctrl;
  logic own_port, timer_write;
  assign own_port = port_sel[7:2] == IO_BASE[7:2];
  assign timer_write = write_rise && code_now == `CODE_PORT_WRITE && own_port
    && port_sel[1:0] == `PORT_TIMER;

  // The code is taken on the write strobe, so it is stable for the whole bus cycle.
  always_comb begin
    next_code_now = code_now;
    next_port_sel = port_sel;
    next_program_counter = program_counter;
    next_saved_program_counter = saved_program_counter;
    next_data_counter = data_counter;
    next_port_a = port_a;
    next_port_b = port_b;
    next_int_ctrl = int_ctrl;
    if (write_rise) begin // R8
      next_code_now = BUS_CONTROL_CODE;
      case (code_now)
        `CODE_FETCH, `CODE_BRANCH, `CODE_OPERAND_PC: next_program_counter = program_counter + 16'h0001;
        `CODE_OPERAND_DC: next_data_counter = data_counter + 16'h0001;
        `CODE_PC_HI_LOAD: next_program_counter[15:8] = DB_IN;
        `CODE_PC_LO_LOAD: next_program_counter[7:0] = DB_IN;
        `CODE_SPC_HI_LOAD: next_saved_program_counter[15:8] = DB_IN;
        `CODE_SPC_LO_LOAD: next_saved_program_counter[7:0] = DB_IN;
        `CODE_DC_HI_LOAD: next_data_counter[15:8] = DB_IN;
        `CODE_DC_LO_LOAD: next_data_counter[7:0] = DB_IN;
        `CODE_PORT_SELECT: next_port_sel = DB_IN;
        `CODE_PORT_WRITE: begin
          if (own_port) begin // R4
            case (port_sel[1:0])
              `PORT_DATA_A: next_port_a = DB_IN;
              `PORT_DATA_B: next_port_b = DB_IN;
              `PORT_INT_CTRL: next_int_ctrl = DB_IN;
              default: ;
            endcase
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      // A fetch code here would drive the bus before the processor has issued anything.
      code_now <= `CODE_NO_TRANSFER;
      port_sel <= '0;
      program_counter <= '0;
      saved_program_counter <= '0;
      data_counter <= '0;
      port_a <= '0;
      port_b <= '0;
      int_ctrl <= '0;
    end else begin
      code_now <= next_code_now;
      port_sel <= next_port_sel;
      program_counter <= next_program_counter;
      saved_program_counter <= next_saved_program_counter;
      data_counter <= next_data_counter;
      port_a <= next_port_a;
      port_b <= next_port_b;
      int_ctrl <= next_int_ctrl;
    end
  end

  // ==========================================================
  // Timer and interrupt
  logic [7:0] timer, next_timer, timer_load, next_timer_load, prescale, next_prescale;
  source_type pending, next_pending;
  logic timer_hit, grant, int_ack;
  logic next_int_req_b, next_prio_out;
  assign grant = pending != SRC_NONE && !PRIORITY_CHAIN_IN;
  assign int_ack = write_rise && code_now == `CODE_VECTOR_HI && grant;

  always_comb begin
    next_timer = timer;
    next_timer_load = timer_load;
    next_prescale = prescale;
    timer_hit = 1'b0;
    if (timer_write) begin
      next_timer_load = DB_IN;
      next_timer = DB_IN;
      next_prescale = TIMER_PRESCALE;
    end else if (phi_rise && int_ctrl[`CTRL_TIMER_ENABLE]) begin // R8
      if (prescale == 8'h00) begin
        next_prescale = TIMER_PRESCALE;
        if (timer <= 8'h01) begin
          next_timer = timer_load;
          timer_hit = 1'b1;
        end else begin
          next_timer = timer - 8'h01;
        end
      end else begin
        next_prescale = prescale - 8'h01;
      end
    end
    // A new event wins over the acknowledge that lands in the same cycle.
    next_pending = int_ack ? SRC_NONE : pending;
    if (ext_fall && int_ctrl[`CTRL_EXT_ENABLE]) begin
      next_pending = SRC_EXT;
    end else if (timer_hit && int_ctrl[`CTRL_TIMER_ENABLE]) begin
      next_pending = SRC_TIMER;
    end
    next_int_req_b = !grant; // R5 R6
    // The chain passes on only while we are enabled and hold nothing.
    next_prio_out = PRIORITY_CHAIN_IN || pending != SRC_NONE;
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      timer <= '0;
      timer_load <= '0;
      prescale <= '0;
      pending <= SRC_NONE;
      INT_REQ_B <= 1'b1;
      PRIORITY_CHAIN_OUT <= 1'b1;
    end else begin
      timer <= next_timer;
      timer_load <= next_timer_load;
      prescale <= next_prescale;
      pending <= next_pending;
      INT_REQ_B <= next_int_req_b;
      PRIORITY_CHAIN_OUT <= next_prio_out;
    end
  end

  // ==========================================================
  // Data bus drive
  drive_type drive;
  logic [15:0] vector;
  logic pc_in_seg, dc_in_seg;
  assign vector = pending == SRC_EXT ? EXT_VECTOR : TIMER_VECTOR;
  assign pc_in_seg = (program_counter >> SEG_BITS) == (SEGMENT_BASE >> SEG_BITS);
  assign dc_in_seg = (data_counter >> SEG_BITS) == (SEGMENT_BASE >> SEG_BITS);

  always_comb begin
    drive.enable = 1'b0; // R9
    drive.data = 8'h00;
    case (code_now)
      `CODE_FETCH, `CODE_BRANCH, `CODE_OPERAND_PC: begin
        drive.enable = pc_in_seg; // R7
        drive.data = rom[program_counter[SEG_BITS-1:0]];
      end
      `CODE_OPERAND_DC: begin
        drive.enable = dc_in_seg; // R7
        drive.data = rom[data_counter[SEG_BITS-1:0]];
      end
      `CODE_VECTOR_LO: begin
        drive.enable = grant; // R1
        drive.data = vector[7:0];
      end
      `CODE_VECTOR_HI: begin
        drive.enable = grant; // R2
        drive.data = vector[15:8];
      end
      `CODE_PORT_READ: begin
        drive.enable = own_port; // R3
        case (port_sel[1:0])
          `PORT_DATA_A: drive.data = port_a;
          `PORT_DATA_B: drive.data = port_b;
          `PORT_INT_CTRL: drive.data = int_ctrl;
          default: drive.data = timer;
        endcase
      end
      `CODE_PC_LO_OUT: begin
        drive.enable = pc_in_seg;
        drive.data = program_counter[7:0];
      end
      `CODE_PC_HI_OUT: begin
        drive.enable = pc_in_seg;
        drive.data = program_counter[15:8];
      end
      default: ;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      DB_OUT <= '0;
      DB_OE_B <= 1'b1;
      DATA_BUS_DRIVE_FLAG <= 1'b0;
      PORT_A <= '0;
      PORT_B <= '0;
    end else begin
      DB_OUT <= drive.data;
      DB_OE_B <= !drive.enable;
      DATA_BUS_DRIVE_FLAG <= drive.enable;
      PORT_A <= next_port_a;
      PORT_B <= next_port_b;
    end
  end

  // ==========================================================
  // Assertions
  property p_vec_lo;
    @(posedge CLK) disable iff (!RST_B)
      (code_now == `CODE_VECTOR_LO && grant) |=> (!DB_OE_B && DB_OUT == $past(vector[7:0]));
  endproperty
  a_vec_lo: assert property (p_vec_lo) else $error("vector low byte not driven"); // R1
  property p_vec_hi;
    @(posedge CLK) disable iff (!RST_B)
      (code_now == `CODE_VECTOR_HI && grant) |=> (!DB_OE_B && DB_OUT == $past(vector[15:8]));
  endproperty
  a_vec_hi: assert property (p_vec_hi) else $error("vector high byte not driven"); // R2
  property p_port_read;
    @(posedge CLK) disable iff (!RST_B)
      (code_now == `CODE_PORT_READ && own_port && port_sel[1:0] == `PORT_DATA_A)
        |=> (!DB_OE_B && DB_OUT == $past(port_a));
  endproperty
  a_port_read: assert property (p_port_read) else $error("port byte not driven"); // R3
  property p_port_write;
    @(posedge CLK) disable iff (!RST_B)
      (write_rise && code_now == `CODE_PORT_WRITE && own_port && port_sel[1:0] == `PORT_DATA_B)
        |=> (PORT_B == $past(DB_IN)) ##1 (PORT_B == port_b);
  endproperty
  a_port_write: assert property (p_port_write) else $error("port byte not loaded"); // R4
  property p_req_chain;
    @(posedge CLK) disable iff (!RST_B)
      !INT_REQ_B |-> ($past(PRIORITY_CHAIN_IN) == 1'b0 && $past(pending) != SRC_NONE);
  endproperty
  a_req_chain: assert property (p_req_chain) else $error("request without chain enable"); // R5
  property p_req_pending;
    @(posedge CLK) disable iff (!RST_B)
      ($rose(!PRIORITY_CHAIN_IN) && pending != SRC_NONE) |=> !INT_REQ_B;
  endproperty
  a_req_pending: assert property (p_req_pending) else $error("pending request not raised"); // R6
  property p_segment;
    @(posedge CLK) disable iff (!RST_B)
      (code_now == `CODE_FETCH && !pc_in_seg) |=> DB_OE_B;
  endproperty
  a_segment: assert property (p_segment) else $error("drove outside own segment"); // R7
  property p_timer_step;
    @(posedge CLK) disable iff (!RST_B)
      (!phi_rise && !timer_write) |=> $stable(timer);
  endproperty
  a_timer_step: assert property (p_timer_step) else $error("timer moved without phase"); // R8
  property p_release;
    @(posedge CLK) disable iff (!RST_B)
      (code_now == `CODE_PORT_WRITE || code_now == `CODE_PC_LO_LOAD) |=> (DB_OE_B && !DATA_BUS_DRIVE_FLAG);
  endproperty
  a_release: assert property (p_release) else $error("drove on processor cycle"); // R9
  c_vector: cover property (@(posedge CLK) disable iff (!RST_B) int_ack);
  c_port_write: cover property (@(posedge CLK) disable iff (!RST_B) timer_write);
  c_timer_hit: cover property (@(posedge CLK) disable iff (!RST_B) timer_hit);
endmodule // memory_bus_responder
`default_nettype wire

// ===== tb/host_bus_model.sv
// Host processor model that issues bus-control codes, strobes and the phase clock.
`timescale 1ns/1ns
`default_nettype none
module host_bus_model (
  input wire logic clk,
  input wire logic [7:0] db_out,
  input wire logic db_oe_b,
  output logic phi,
  output logic write_strobe,
  output logic [4:0] code,
  output logic [7:0] db_in
);
  logic host_en;
  logic [7:0] host_data;
  logic [7:0] last;
  initial begin
    phi = 1'b0;
    write_strobe = 1'b0;
    code = 5'h00;
    host_en = 1'b0;
    host_data = 8'h00;
    last = 8'h00;
  end
  // A released bus has no pull, so it shows a changing pattern and a stale byte never matches.
  assign db_in = !db_oe_b ? db_out : (host_en ? host_data : ~last);
  always @(posedge clk) begin
    phi <= ~phi;
    last <= db_in;
  end
  // ==========================================================================
  // One bus cycle; outputs for the new code are settled when it returns.
  task automatic cycle(input logic [4:0] c, input logic drives, input logic [7:0] d);
    @(posedge clk);
    code <= c;
    write_strobe <= 1'b1;
    @(posedge clk);
    write_strobe <= 1'b0;
    host_en <= drives;
    host_data <= d;
    @(posedge clk);
    @(posedge clk);
    #1;
  endtask
endmodule // host_bus_model
`default_nettype wire

// ===== tb/memory_bus_responder_tb_top.sv
// Self-checking bench for the memory bus responder.
`timescale 1ns/1ns
`default_nettype none
module memory_bus_responder_tb_top;
  localparam logic [7:0] io_base = 8'h04;
  logic clk;
  logic rst_b;
  logic priority_chain_in;
  logic external_interrupt_input;
  wire logic phi;
  wire logic strobe;
  wire logic [4:0] code;
  wire logic [7:0] db_in;
  wire logic [7:0] db_out;
  wire logic [7:0] port_a;
  wire logic [7:0] port_b;
  wire logic oe_b;
  wire logic drive_flag;
  wire logic int_req_b;
  wire logic priority_chain_out;
  int error_cnt = 0;
  int checked = 0;
  int cycles = 0;
  memory_bus_responder #(.IO_BASE(io_base), .EXT_VECTOR(16'h0080), .TIMER_VECTOR(16'h0c31),
    .TIMER_PRESCALE(8'h01)) dut (
    .CLK(clk),
    .RST_B(rst_b),
    .PHI(phi),
    .WRITE_STROBE(strobe),
    .BUS_CONTROL_CODE(code),
    .DB_IN(db_in),
    .PRIORITY_CHAIN_IN(priority_chain_in),
    .EXTERNAL_INTERRUPT_INPUT(external_interrupt_input),
    .DB_OUT(db_out),
    .DB_OE_B(oe_b),
    .DATA_BUS_DRIVE_FLAG(drive_flag),
    .INT_REQ_B(int_req_b),
    .PRIORITY_CHAIN_OUT(priority_chain_out),
    .PORT_A(port_a),
    .PORT_B(port_b)
  );
  host_bus_model hbm (
    .clk(clk),
    .db_out(db_out),
    .db_oe_b(oe_b),
    .phi(phi),
    .write_strobe(strobe),
    .code(code),
    .db_in(db_in)
  );
  always #25 clk = ~clk;
  // ==========================================================================
  // Checking helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  task automatic chk_drive(input logic [7:0] exp);
    chk_bit(oe_b, 1'b0);
    chk_bit(drive_flag, 1'b1);
    chk(db_out, exp);
  endtask
  task automatic chk_released;
    chk_bit(oe_b, 1'b1);
    chk_bit(drive_flag, 1'b0);
  endtask
  task automatic finish_test;
    $display("checked %0d compares, %0d mismatches", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic test_reset;
    @(posedge clk);
    #1;
    chk_released;
    chk_bit(int_req_b, 1'b1);
    chk(port_a, 8'h00);
    chk(port_b, 8'h00);
  endtask
  task automatic test_ports;
    hbm.cycle(5'h1c, 1'b1, io_base);
    hbm.cycle(5'h1a, 1'b1, 8'h5a);
    hbm.cycle(5'h1c, 1'b1, io_base + 8'h01);
    chk(port_a, 8'h5a);
    hbm.cycle(5'h1a, 1'b1, 8'ha5);
    chk_released;
    hbm.cycle(5'h1b, 1'b0, 8'h00);
    chk(port_b, 8'ha5);
    chk_drive(8'ha5);
    hbm.cycle(5'h1c, 1'b1, 8'h20);
    hbm.cycle(5'h1b, 1'b0, 8'h00);
    chk_released;
    hbm.cycle(5'h1c, 1'b1, io_base);
    hbm.cycle(5'h1b, 1'b0, 8'h00);
    chk_drive(8'h5a);
  endtask
  task automatic test_memory;
    logic [4:0] quiet [6] = '{5'h15, 5'h16, 5'h18, 5'h19, 5'h04, 5'h1d};
    hbm.cycle(5'h14, 1'b1, 8'h00);
    chk_released;
    hbm.cycle(5'h17, 1'b1, 8'h10);
    hbm.cycle(5'h1e, 1'b0, 8'h00);
    chk_drive(8'h10);
    hbm.cycle(5'h1f, 1'b0, 8'h00);
    chk_drive(8'h00);
    hbm.cycle(5'h00, 1'b0, 8'h00);
    chk_drive(8'h10);
    hbm.cycle(5'h00, 1'b0, 8'h00);
    chk_drive(8'h11);
    foreach (quiet[i]) begin
      hbm.cycle(quiet[i], 1'b1, 8'h00);
      chk_released;
    end
    hbm.cycle(5'h19, 1'b1, 8'h25);
    hbm.cycle(5'h02, 1'b0, 8'h00);
    chk_drive(8'h25);
    hbm.cycle(5'h02, 1'b0, 8'h00);
    chk_drive(8'h26);
    // Moving the program counter above the segment must silence the codes that read through it.
    hbm.cycle(5'h14, 1'b1, 8'h80);
    hbm.cycle(5'h00, 1'b0, 8'h00);
    chk_released;
    hbm.cycle(5'h1e, 1'b0, 8'h00);
    chk_released;
    hbm.cycle(5'h03, 1'b0, 8'h00);
    chk_released;
  endtask
  task automatic test_interrupt;
    hbm.cycle(5'h1c, 1'b1, io_base + 8'h02);
    hbm.cycle(5'h1a, 1'b1, 8'h01);
    hbm.cycle(5'h1c, 1'b1, 8'h20);
    @(posedge clk) external_interrupt_input <= 1'b0;
    repeat (4) @(posedge clk);
    external_interrupt_input <= 1'b1;
    #1;
    chk_bit(int_req_b, 1'b1);
    chk_bit(priority_chain_out, 1'b1);
    hbm.cycle(5'h0f, 1'b0, 8'h00);
    chk_released;
    @(posedge clk) priority_chain_in <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk_bit(int_req_b, 1'b0);
    chk_bit(priority_chain_out, 1'b1);
    hbm.cycle(5'h0f, 1'b0, 8'h00);
    chk_drive(8'h80);
    hbm.cycle(5'h13, 1'b0, 8'h00);
    chk_drive(8'h00);
    hbm.cycle(5'h1c, 1'b1, 8'h20);
    chk_bit(int_req_b, 1'b1);
    chk_bit(priority_chain_out, 1'b0);
  endtask
  task automatic test_timer;
    hbm.cycle(5'h1c, 1'b1, io_base + 8'h03);
    hbm.cycle(5'h1a, 1'b1, 8'h03);
    hbm.cycle(5'h1b, 1'b0, 8'h00);
    chk_drive(8'h03);
    hbm.cycle(5'h1c, 1'b1, io_base + 8'h02);
    hbm.cycle(5'h1a, 1'b1, 8'h02);
    hbm.cycle(5'h1c, 1'b1, 8'h20);
    chk_bit(int_req_b, 1'b1);
    // The count needs several phase rises, so the request cannot have come yet above.
    repeat (24) @(posedge clk);
    #1;
    chk_bit(int_req_b, 1'b0);
    hbm.cycle(5'h0f, 1'b0, 8'h00);
    chk_drive(8'h31);
    hbm.cycle(5'h13, 1'b0, 8'h00);
    chk_drive(8'h0c);
  endtask
  // ==========================================================================
  // Main sequence and hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      error_cnt++;
      finish_test;
    end
  end
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    priority_chain_in = 1'b1;
    external_interrupt_input = 1'b1;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    test_reset;
    test_ports;
    test_memory;
    test_interrupt;
    test_timer;
    finish_test;
  end
endmodule // memory_bus_responder_tb_top
`default_nettype wire
